// ==== strap_latch_defines.svh ====
// Register offsets, field positions and reset values of the strap latch
`ifndef STRAP_LATCH_DEFINES_SVH
`define STRAP_LATCH_DEFINES_SVH

`define STRAP_STATUS_OFF   8'h00
`define BOOT_STATUS_OFF    8'h04
`define STRAP_CTRL_OFF     8'h08

`define STRAP_BIT_A        0
`define STRAP_BIT_B        1
`define STRAP_BIT_C        2
`define STRAP_VALID_BIT    3

`define BOOT_MODE_LSB      0
`define BOOT_MODE_MSB      1
`define BOOT_PRINT_BIT     2
`define BOOT_ERROR_BIT     3
`define BOOT_DECIDED_BIT   4

`define CTRL_PRINT_MASK    0
`define CTRL_RESET_VAL     1'b0

`define PIN_C_PULL_LEVEL   1'b1

`define PRINT_FUSE_ALWAYS  2'h0
`define PRINT_FUSE_B_LOW   2'h1
`define PRINT_FUSE_B_HIGH  2'h2
`define PRINT_FUSE_NEVER   2'h3

`endif

// ==== strap_pkg.sv ====
// Types shared by the strap latch modules
package strap_pkg;

  typedef enum logic [1:0] {
    BOOT_UNDEF    = 2'b00,
    BOOT_FLASH    = 2'b01,
    BOOT_DOWNLOAD = 2'b10,
    BOOT_INVALID  = 2'b11
  } boot_mode_type;

  typedef enum logic [1:0] {
    ST_SHUTDOWN = 2'b00,
    ST_CAPTURE  = 2'b01,
    ST_HOLD     = 2'b10
  } cap_state_type;

endpackage

// ==== strap_if.sv ====
// Captured straps and boot decisions passed between capture and decoder
`timescale 1ns/100ps
interface strap_if;
  import strap_pkg::*;
  logic [2:0]    cap_bits;
  logic          cap_valid;
  logic [1:0]    fuse;
  boot_mode_type boot_mode;
  logic          print_en;
  logic          mode_error;
  logic          decided;

  modport capture (
    output cap_bits,
    output cap_valid,
    output fuse,
    input  boot_mode,
    input  print_en,
    input  mode_error,
    input  decided
  );

  modport decoder (
    input  cap_bits,
    input  cap_valid,
    input  fuse,
    output boot_mode,
    output print_en,
    output mode_error,
    output decided
  );
endinterface

// ==== boot_decode.sv ====
// Boot mode and print enable decision taken once from the captured straps
`timescale 1ns/100ps
`include "strap_latch_defines.svh"
module boot_decode (
  input  wire logic clk,
  input  wire logic rst_n,
  strap_if.decoder  sif
);
  import strap_pkg::*;

  boot_mode_type mode_reg;
  logic          print_reg;
  logic          error_reg;
  logic          decided_reg;
  boot_mode_type mode_next;
  logic          print_next;
  logic          bit_a;
  logic          bit_b;
  logic          bit_c;
  logic          take;

  assign bit_a = sif.cap_bits[`STRAP_BIT_A];
  assign bit_b = sif.cap_bits[`STRAP_BIT_B];
  assign bit_c = sif.cap_bits[`STRAP_BIT_C];
  assign take  = sif.cap_valid & ~decided_reg;

  // Flash wins when a and c set, download needs a, b set and c clear
  assign mode_next = (bit_a & bit_c)          ? BOOT_FLASH :
                     (bit_a & bit_b & ~bit_c) ? BOOT_DOWNLOAD :
                     (~bit_b & ~bit_c)        ? BOOT_INVALID :
                                                BOOT_UNDEF;

  assign print_next = (sif.fuse == `PRINT_FUSE_ALWAYS) ? 1'b1 :
                      (sif.fuse == `PRINT_FUSE_B_LOW)  ? ~bit_b :
                      (sif.fuse == `PRINT_FUSE_B_HIGH) ? bit_b :
                                                         1'b0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg    <= BOOT_UNDEF;
      print_reg   <= 1'b0;
      error_reg   <= 1'b0;
      decided_reg <= 1'b0;
    end else if (take) begin
      mode_reg    <= mode_next;
      print_reg   <= print_next;
      error_reg   <= ~bit_b & ~bit_c;
      decided_reg <= 1'b1;
    end else if (!sif.cap_valid) begin
      decided_reg <= 1'b0;
    end
  end

  assign sif.boot_mode  = mode_reg;
  assign sif.print_en   = print_reg;
  assign sif.mode_error = error_reg;
  assign sif.decided    = decided_reg;

  flash_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
    take && bit_a && bit_c |=> mode_reg == BOOT_FLASH)
    else $error("flash boot not selected");

  download_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
    take && bit_a && bit_b && !bit_c |=> mode_reg == BOOT_DOWNLOAD)
    else $error("download boot not selected");

  print_decode_a: assert property (@(posedge clk) disable iff (!rst_n)
    take |=> print_reg == (($past(sif.fuse) == 2'h0) ||
                           ($past(sif.fuse) == 2'h1 && !$past(bit_b)) ||
                           ($past(sif.fuse) == 2'h2 && $past(bit_b))))
    else $error("print enable decode wrong");

  decision_stable_a: assert property (@(posedge clk) disable iff (!rst_n)
    decided_reg && $past(decided_reg) |-> $stable(mode_reg) && $stable(print_reg))
    else $error("boot decision changed while held");

  mode_error_a: assert property (@(posedge clk) disable iff (!rst_n)
    take && !bit_b && !bit_c |=> error_reg && mode_reg == BOOT_INVALID)
    else $error("invalid straps not flagged");

  download_seen_c: cover property (@(posedge clk) disable iff (!rst_n)
    decided_reg && mode_reg == BOOT_DOWNLOAD);

  error_seen_c: cover property (@(posedge clk) disable iff (!rst_n)
    decided_reg && error_reg);

endmodule // boot_decode

// ==== strap_latch_boot_select.sv ====
// Strap capture, hold and Wishbone status access for boot selection
//
// What this block does
// - Sample all three straps at every system reset
// - Keep captured bits until shutdown or power down
// - Software reads captured bits via strap status
// - Undriven third strap pin captures as one
// - After release, pins return to normal I/O
// - Flash on a,c set; download on a,b,~c
// - Print enable from fuse field and strap b
`timescale 1ns/100ps
`include "strap_latch_defines.svh"
module strap_latch_boot_select (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    chip_en,
  input  wire logic                    boot_cfg_pin_a,
  input  wire logic                    boot_cfg_pin_b,
  input  wire logic                    boot_cfg_pin_c,
  input  wire logic                    boot_cfg_pin_c_driven,
  input  wire logic [1:0]              print_ctrl_fuse,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [7:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic [31:0]                  wb_dat_o,
  output logic                         wb_ack_o,
  output strap_pkg::boot_mode_type     boot_mode,
  output logic                         boot_mode_error,
  output logic                         print_enable,
  output logic                         strap_valid,
  output logic                         normal_io_en
);
  import strap_pkg::*;

  strap_if sif ();

  cap_state_type state_reg;
  cap_state_type state_next;
  logic [2:0]    bits_reg;
  logic [1:0]    fuse_reg;
  logic          valid_reg;
  logic          io_reg;
  logic          print_out_reg;
  logic          mask_reg;
  logic          ack_reg;
  logic [31:0]   dat_reg;
  logic [2:0]    pin_sample;
  logic          do_capture;
  logic          wb_req;
  logic          wb_rd_take;
  logic          wb_wr_take;
  logic          sel_strap;
  logic          sel_boot;
  logic          sel_ctrl;
  logic [31:0]   strap_word;
  logic [31:0]   boot_word;
  logic [31:0]   ctrl_word;
  logic [31:0]   rd_data;

  // Third pin falls back to its pull-up level when nobody drives it
  assign pin_sample = {boot_cfg_pin_c_driven ? boot_cfg_pin_c : `PIN_C_PULL_LEVEL,
                       boot_cfg_pin_b,
                       boot_cfg_pin_a};

  assign do_capture = (state_reg == ST_CAPTURE) & chip_en;

  // Capture sequencing
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_SHUTDOWN: begin
        if (chip_en) begin
          state_next = ST_CAPTURE;
        end
      end
      ST_CAPTURE: begin
        if (chip_en) begin
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!chip_en) begin
          state_next = ST_SHUTDOWN;
        end
      end
      default: begin
        state_next = ST_SHUTDOWN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_CAPTURE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Straps and fuse taken once per reset or power up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bits_reg  <= 3'h0;
      fuse_reg  <= 2'h0;
      valid_reg <= 1'b0;
    end else if (do_capture) begin
      bits_reg  <= pin_sample;
      fuse_reg  <= print_ctrl_fuse;
      valid_reg <= 1'b1;
    end else if (state_reg == ST_SHUTDOWN) begin
      valid_reg <= 1'b0;
    end
  end

  // Pins go back to ordinary use once the straps are held
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io_reg <= 1'b0;
    end else begin
      io_reg <= (state_next == ST_HOLD);
    end
  end

  assign sif.cap_bits  = bits_reg;
  assign sif.cap_valid = valid_reg;
  assign sif.fuse      = fuse_reg;

  boot_decode u_decode (
    .clk   (clk),
    .rst_n (rst_n),
    .sif   (sif)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      print_out_reg <= 1'b0;
    end else begin
      print_out_reg <= sif.decided & sif.print_en & ~mask_reg;
    end
  end

  // Wishbone decode
  assign wb_req     = wb_cyc_i & wb_stb_i;
  assign wb_rd_take = wb_req & ~wb_we_i & ~ack_reg;
  assign wb_wr_take = wb_req & wb_we_i & ack_reg;
  assign sel_strap  = (wb_adr_i == `STRAP_STATUS_OFF);
  assign sel_boot   = (wb_adr_i == `BOOT_STATUS_OFF);
  assign sel_ctrl   = (wb_adr_i == `STRAP_CTRL_OFF);

  assign strap_word = {28'h0000000, valid_reg, bits_reg};
  assign boot_word  = {27'h0, sif.decided, sif.mode_error, sif.print_en,
                       sif.boot_mode};
  assign ctrl_word  = {31'h0, mask_reg};
  assign rd_data    = sel_strap ? strap_word :
                      sel_boot  ? boot_word :
                      sel_ctrl  ? ctrl_word :
                                  32'h00000000;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_req & ~ack_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dat_reg <= 32'h00000000;
    end else if (wb_rd_take) begin
      dat_reg <= rd_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg <= `CTRL_RESET_VAL;
    end else if (wb_wr_take & sel_ctrl & wb_sel_i[0]) begin
      mask_reg <= wb_dat_i[`CTRL_PRINT_MASK];
    end
  end

  assign wb_dat_o        = dat_reg;
  assign wb_ack_o        = ack_reg;
  assign boot_mode       = sif.boot_mode;
  assign boot_mode_error = sif.mode_error;
  assign print_enable    = print_out_reg;
  assign strap_valid     = valid_reg;
  assign normal_io_en    = io_reg;

  capture_take_a: assert property (@(posedge clk) disable iff (!rst_n)
    do_capture |=> valid_reg && bits_reg == $past(pin_sample))
    else $error("strap capture missed pin levels");

  pullup_c_a: assert property (@(posedge clk) disable iff (!rst_n)
    do_capture && !boot_cfg_pin_c_driven |=> bits_reg[2])
    else $error("undriven third strap not captured as one");

  bits_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == ST_HOLD && $past(state_reg) == ST_HOLD |-> $stable(bits_reg))
    else $error("captured straps changed while held");

  io_release_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(valid_reg) |-> io_reg ##1 (io_reg || state_reg != ST_HOLD))
    else $error("pins not released to normal use");

  status_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    wb_rd_take && sel_strap ##1 wb_req |-> ack_reg &&
    dat_reg == {28'h0000000, $past(valid_reg), $past(bits_reg)})
    else $error("strap status read returned wrong value");

  ack_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    ack_reg |=> !ack_reg)
    else $error("bus ack held longer than one cycle");

  print_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
    mask_reg |=> !print_out_reg)
    else $error("masked print enable still driven");

  capture_seen_c: cover property (@(posedge clk) disable iff (!rst_n)
    do_capture ##1 state_reg == ST_HOLD);

  status_read_c: cover property (@(posedge clk) disable iff (!rst_n)
    wb_rd_take && sel_strap ##1 ack_reg);

  recapture_c: cover property (@(posedge clk) disable iff (!rst_n)
    state_reg == ST_SHUTDOWN ##[1:20] do_capture);

endmodule // strap_latch_boot_select

// ==== strap_host_model.sv ====
// Far-side strap driver: pull resistors or host GPIO outputs
`timescale 1ns/100ps
module strap_host_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       chip_en,
  input  wire logic [2:0] cfg,
  input  wire logic       drive_c,
  output logic            pin_a,
  output logic            pin_b,
  output logic            pin_c,
  output logic            pin_c_driven
);
  localparam logic [3:0] HOLD = 4'h4;
  logic [3:0] hold_reg;
  logic       flip_reg;
  logic       holding;
  assign holding = (hold_reg < HOLD);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_reg <= 4'h0;
      flip_reg <= 1'b0;
    end else if (!chip_en) begin
      hold_reg <= 4'h0;
    end else begin
      if (holding) hold_reg <= hold_reg + 4'h1;
      flip_reg <= ~flip_reg;
    end
  end
  // Straps held over reset and hold time, then pins busy as GPIO
  assign pin_a = holding ? cfg[0] : (~cfg[0] ^ flip_reg);
  assign pin_b = holding ? cfg[1] : (~cfg[1] ^ flip_reg);
  // Undriven pin c rests at its pull-up level
  assign pin_c = drive_c ? (holding ? cfg[2] : (~cfg[2] ^ flip_reg)) : 1'b1;
  assign pin_c_driven = drive_c;
endmodule // strap_host_model

// ==== tb_top.sv ====
// Self-checking bench for the strap latch and boot select block
`timescale 1ns/100ps
`include "strap_latch_defines.svh"
module tb_top;
  import strap_pkg::*;
  logic          clk, rst_n, chip_en, drive_c, cyc, stb, we, ack;
  logic          err, pen, sv, nio, pa, pb, pc, pcd;
  logic [2:0]    cfg;
  logic [1:0]    fuse;
  logic [7:0]    adr;
  logic [31:0]   wdat, rdat, dat_o;
  boot_mode_type mode;
  int            n_errors, n_compared, ticks;
  // Rows are {fuse, pin c driven, c, b, a}
  logic [5:0] cases [7] = '{6'b001101, 6'b011011, 6'b101011, 6'b110001,
                            6'b011110, 6'b011001, 6'b101111};

  strap_host_model i_host (.clk(clk), .rst_n(rst_n), .chip_en(chip_en), .cfg(cfg),
    .drive_c(drive_c), .pin_a(pa), .pin_b(pb), .pin_c(pc), .pin_c_driven(pcd));
  strap_latch_boot_select i_dut (.clk(clk), .rst_n(rst_n), .chip_en(chip_en),
    .boot_cfg_pin_a(pa), .boot_cfg_pin_b(pb), .boot_cfg_pin_c(pc),
    .boot_cfg_pin_c_driven(pcd), .print_ctrl_fuse(fuse), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .boot_mode(mode), .boot_mode_error(err),
    .print_enable(pen), .strap_valid(sv), .normal_io_en(nio));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic tally_and_finish();
    if (n_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk) begin
    ticks++;
    if (ticks > 3000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    r = dat_o;
    cyc <= 1'b0; stb <= 1'b0;
  endtask

  task automatic boot(input logic [5:0] c);
    @(posedge clk);
    rst_n <= 1'b0; {fuse, drive_c, cfg} <= c;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask

  function automatic logic [31:0] exp_boot(input logic [2:0] s, input logic [1:0] f);
    logic [1:0] m;
    logic       p;
    m = (s[0] & s[2]) ? BOOT_FLASH : (s[0] & s[1] & ~s[2]) ? BOOT_DOWNLOAD :
        (~s[1] & ~s[2]) ? BOOT_INVALID : BOOT_UNDEF;
    p = (f == 2'h0) | ((f == 2'h1) & ~s[1]) | ((f == 2'h2) & s[1]);
    return {27'h0, 1'b1, ~s[1] & ~s[2], p, m};
  endfunction

  task automatic run_case(input logic [5:0] c);
    logic [2:0]  s;
    logic [31:0] eb;
    boot(c);
    s = {c[3] ? c[2] : 1'b1, c[1:0]};
    eb = exp_boot(s, c[5:4]);
    wb(1'b0, `STRAP_STATUS_OFF, 32'h0, rdat);
    chk(rdat, {28'h0, 1'b1, s});
    wb(1'b0, `BOOT_STATUS_OFF, 32'h0, rdat);
    chk(rdat, eb);
    chk({30'h0, mode}, {30'h0, eb[1:0]});
    chk({28'h0, sv, err, pen, nio}, {28'h0, 1'b1, eb[3], eb[2], 1'b1});
    fuse <= ~fuse;
    repeat (4) @(posedge clk);
    wb(1'b0, `STRAP_STATUS_OFF, 32'h0, rdat);
    chk(rdat, {28'h0, 1'b1, s});
    wb(1'b0, `BOOT_STATUS_OFF, 32'h0, rdat);
    chk(rdat, eb);
    chk({31'h0, pen}, {31'h0, eb[2]});
  endtask

  initial begin
    rst_n = 1'b0; chip_en = 1'b1; drive_c = 1'b1; cfg = 3'h0; fuse = 2'h0;
    cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; wdat = 32'h0;
    // Row six breaks the b and c rule on purpose
    foreach (cases[i]) run_case(cases[i]);
    wb(1'b1, `STRAP_CTRL_OFF, 32'h1, rdat);
    wb(1'b0, `STRAP_CTRL_OFF, 32'h0, rdat);
    chk(rdat, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, pen}, 32'h0);
    wb(1'b1, `STRAP_STATUS_OFF, 32'h0, rdat);
    wb(1'b1, 8'h0C, 32'hFFFFFFFF, rdat);
    wb(1'b0, 8'h0C, 32'h0, rdat);
    chk(rdat, 32'h0);
    wb(1'b0, `STRAP_STATUS_OFF, 32'h0, rdat);
    chk(rdat, 32'hF);
    boot(6'b001101);
    wb(1'b0, `STRAP_CTRL_OFF, 32'h0, rdat);
    chk(rdat, 32'h0);
    chip_en <= 1'b0; cfg <= 3'b011; fuse <= 2'h1;
    repeat (3) @(posedge clk);
    chk({30'h0, sv, nio}, 32'h0);
    chip_en <= 1'b1;
    repeat (6) @(posedge clk);
    wb(1'b0, `STRAP_STATUS_OFF, 32'h0, rdat);
    chk(rdat, 32'hB);
    wb(1'b0, `BOOT_STATUS_OFF, 32'h0, rdat);
    chk(rdat, exp_boot(3'b011, 2'h1));
    tally_and_finish();
  end
endmodule // tb_top
